// ===== common/seea_defines.svh
// Constants for the serial EEPROM addressing front end
`ifndef SEEA_DEFINES_SVH
`define SEEA_DEFINES_SVH
`define SEEA_DEVICE_CODE 4'hA
`define SEEA_CODE_MSB 7
`define SEEA_CODE_LSB 4
`define SEEA_SEL_MSB 3
`define SEEA_SEL_LSB 1
`define SEEA_RW_BIT 0
`define SEEA_RW_READ 1'h1
`define SEEA_BLOCK_WORDS 256
`define SEEA_ONE_BYTE_MAX_KBIT 16
`define SEEA_BITS_PER_BYTE 4'h8
`define SEEA_ACK_SLOT 4'h8
`define SEEA_MAX_ADDR_BITS 16
`endif

// ===== common/seea_pkg.sv
// Types shared by the serial EEPROM addressing front end
package seea_pkg;
	typedef enum logic [2:0] {
		SEEA_IDLE = 3'b000,
		SEEA_CTRL = 3'b001,
		SEEA_ADDR_HI = 3'b011,
		SEEA_ADDR_LO = 3'b010,
		SEEA_DATA = 3'b110,
		SEEA_IGNORE = 3'b100
	} seea_state_t;

	typedef struct packed {
		logic [2:0] select;
		logic read;
		logic [15:0] word_address;
	} seea_cmd_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} seea_bus_t;
endpackage

// ===== design/seea_addressing.sv
// Slave-side addressing front end of a two-wire serial EEPROM
//
// How it works
// - First byte after Start is control; accepted only with device code 1010.
// - Without address pins, select bits pick a 256-word block, top address bits; above 16 Kbit they stay out of the address.
// - Up to 2 Kbit all select bits ignored; at 8 Kbit only lowest decoded.
// - Control byte bit 0 selects read when 1, write when 0.
// - After Start, watch data; acknowledge a matching control byte, then address.
// - With address pins, select bits must equal the chip-address pin levels.
// - Chip-select bits let eight devices share a bus; they stay out of the word address.
// - From 32 to 512 Kbit, two bytes after control form the address.
// - Unused upper bits of the high address byte are ignored per density.
// - Upper address byte comes first, then the lower byte.
// - Address counter wraps within this device's own array only.
// - Sixteen Kbit and below take a single address byte.
// - Acknowledge is driven in the ninth clock, after eight bits.
// - No acknowledge to a control byte while a write cycle runs.
// - Start is data falling while clock is high; commands begin with it.
`timescale 1ns/100ps
`include "seea_defines.svh"
module seea_addressing #(
	parameter int DENSITY_KBIT = 64,
	parameter bit HAS_ADDR_PINS = 1'b1
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic [2:0] chip_address_i,
	input wire logic write_busy_i,
	input wire logic addr_advance_i,
	output seea_pkg::seea_cmd_t cmd_o,
	output logic selected_o,
	output logic address_valid_o,
	output logic start_pulse_o,
	output logic stop_pulse_o
);
	import seea_pkg::*;

	// ==========================================================
	// Density derived geometry
	// ==========================================================
	// A density of 0 stands for the 128-bit part, which keeps four address bits
	localparam int ARRAY_BITS = (DENSITY_KBIT < 1) ? 4 : $clog2(DENSITY_KBIT * 128);
	localparam bit TWO_BYTES = (DENSITY_KBIT > `SEEA_ONE_BYTE_MAX_KBIT);
	// The 8 Kbit part decodes only its lowest block-select bit, so half of
	// its array is out of reach of the block bits
	localparam int BLOCK_BITS = (DENSITY_KBIT == 8) ? 1 :
		((ARRAY_BITS > 8) ? ARRAY_BITS - 8 : 0);

	localparam logic [15:0] ARRAY_MASK = 16'(((32'h1) << ARRAY_BITS) - 1);
	localparam logic [2:0] BLOCK_MASK = 3'(((32'h1) << BLOCK_BITS) - 1);

	// Which select bits must match the pins or are decoded as block bits
	function automatic logic select_ok(input logic [2:0] sel, input logic [2:0] pins);
		if (HAS_ADDR_PINS) begin
			select_ok = (sel == pins);
		end else begin
			select_ok = 1'b1;
		end
	endfunction

	// ==========================================================
	// Link side: the bus clock and data lines sampled into the reference domain
	// ==========================================================
	seea_bus_t bus_sync;
	seea_bus_t bus_prev;

	// Both lines idle high, so the synchroniser resets to released
	seea_sync #(
		.WIDTH(2),
		.RESET_VALUE(2'h3)
	) u_bus_sync (
		.clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.async_i({scl_i, sda_i}),
		.sync_o(bus_sync)
	);

	// Chip-address pins may be driven by other logic, so they pass two flops as well
	logic [2:0] pins_sync;
	seea_sync #(
		.WIDTH(3),
		.RESET_VALUE(3'h0)
	) u_pin_sync (
		.clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.async_i(chip_address_i),
		.sync_o(pins_sync)
	);

	// Start detect on the falling bus data edge itself: data falls while clock high.
	// Kept in the link domain so no narrow pulse is missed by sampling.
	logic link_start;
	logic link_rst_n;
	assign link_rst_n = rst_n_i;

	always_ff @(negedge sda_i or negedge link_rst_n) begin
		if (!link_rst_n) begin
			link_start <= 1'b0;
		end else begin
			link_start <= scl_i ? ~link_start : link_start;
		end
	end

	logic link_start_d;
	logic start_evt;
	always_ff @(posedge scl_i or negedge link_rst_n) begin
		if (!link_rst_n) begin
			link_start_d <= 1'b0;
		end else begin
			link_start_d <= link_start;
		end
	end

	// Start event reaches the reference domain by a toggle crossing
	logic [2:0] start_sync;
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			start_sync <= 3'h0;
		end else begin
			start_sync <= {start_sync[1:0], link_start};
		end
	end
	assign start_evt = start_sync[2] ^ start_sync[1];

	// Stop event: data rises while clock high, seen after synchronising
	wire scl_rise = bus_sync.scl & ~bus_prev.scl;
	wire scl_fall = ~bus_sync.scl & bus_prev.scl;
	wire stop_evt = bus_sync.scl & bus_prev.scl & bus_sync.sda & ~bus_prev.sda;

	// The link-side flop after the start toggle only feeds the frame_seen flag
	logic frame_evt;
	seea_event_xfer u_frame_xfer (
		.src_clk_i(scl_i),
		.src_rst_n_i(link_rst_n),
		.src_pulse_i(link_start ^ link_start_d),
		.dst_clk_i(ref_clk_i),
		.dst_rst_n_i(rst_n_i),
		.dst_pulse_o(frame_evt)
	);

	// ==========================================================
	// Byte engine in the reference domain
	// ==========================================================
	seea_state_t state;
	seea_state_t next_state;
	logic [3:0] bit_count;
	logic [7:0] shift;
	logic ack_phase;
	logic ack_drive;
	logic [2:0] select_reg;
	logic read_reg;
	logic [15:0] address;
	logic addr_valid;
	logic frame_seen;

	wire [7:0] next_shift = {shift[6:0], bus_sync.sda};
	wire byte_done = scl_rise && !ack_phase && (bit_count == `SEEA_BITS_PER_BYTE - 4'h1);
	wire code_match = (next_shift[`SEEA_CODE_MSB:`SEEA_CODE_LSB] == `SEEA_DEVICE_CODE);
	wire [2:0] rx_select = next_shift[`SEEA_SEL_MSB:`SEEA_SEL_LSB];
	wire ctrl_match = code_match && select_ok(rx_select, pins_sync) && !write_busy_i;
	wire rx_read = (next_shift[`SEEA_RW_BIT] == `SEEA_RW_READ);

	// Block bits sit above the in-block address; pin devices keep them apart.
	// They come from the stored control byte, not from the byte now arriving.
	wire [15:0] block_part = HAS_ADDR_PINS ? 16'h0000 :
		(16'({13'h0000, select_reg & BLOCK_MASK}) << 8);

	always_comb begin
		next_state = state;
		case (state)
			SEEA_IDLE: next_state = state;
			SEEA_CTRL: begin
				if (byte_done) begin
					if (!ctrl_match) begin
						next_state = SEEA_IGNORE;
					end else if (rx_read) begin
						next_state = SEEA_DATA;
					end else begin
						next_state = TWO_BYTES ? SEEA_ADDR_HI : SEEA_ADDR_LO;
					end
				end
			end
			SEEA_ADDR_HI: begin
				if (byte_done) begin
					next_state = SEEA_ADDR_LO;
				end
			end
			SEEA_ADDR_LO: begin
				if (byte_done) begin
					next_state = SEEA_DATA;
				end
			end
			SEEA_DATA: next_state = state;
			SEEA_IGNORE: next_state = state;
			default: next_state = SEEA_IDLE;
		endcase
		if (stop_evt) begin
			next_state = SEEA_IDLE;
		end
		if (start_evt) begin
			next_state = SEEA_CTRL;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= SEEA_IDLE;
			bus_prev <= 2'h3;
			frame_seen <= 1'b0;
		end else begin
			state <= next_state;
			bus_prev <= bus_sync;
			frame_seen <= frame_evt ? 1'b1 : (stop_evt ? 1'b0 : frame_seen);
		end
	end

	// Bit counter and acknowledge slot
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bit_count <= 4'h0;
			shift <= 8'h00;
			ack_phase <= 1'b0;
		end else if (start_evt) begin
			bit_count <= 4'h0;
			ack_phase <= 1'b0;
		end else if (scl_rise) begin
			if (ack_phase) begin
				ack_phase <= 1'b0;
				bit_count <= 4'h0;
			end else begin
				shift <= next_shift;
				bit_count <= bit_count + 4'h1;
				ack_phase <= (bit_count == `SEEA_ACK_SLOT - 4'h1);
			end
		end
	end

	// Drive the low level from the falling edge after the eighth bit until
	// the falling edge that closes the ninth; mismatches never drive.
	logic ack_pending;
	wire ack_wanted = (state == SEEA_CTRL) ? ctrl_match :
		((state == SEEA_ADDR_HI) || (state == SEEA_ADDR_LO));
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack_pending <= 1'b0;
			ack_drive <= 1'b0;
		end else begin
			if (start_evt || stop_evt) begin
				ack_pending <= 1'b0;
				ack_drive <= 1'b0;
			end else begin
				if (byte_done) begin
					ack_pending <= ack_wanted;
				end
				if (scl_fall) begin
					ack_drive <= ack_pending;
					ack_pending <= 1'b0;
				end
			end
		end
	end

	// ==========================================================
	// Command and address capture
	// ==========================================================
	wire [15:0] hi_loaded = {next_shift, address[7:0]} & ARRAY_MASK;
	wire [15:0] lo_loaded = TWO_BYTES ? ({address[15:8], next_shift} & ARRAY_MASK) :
		((block_part | {8'h00, next_shift}) & ARRAY_MASK);
	wire [15:0] next_addr = (address + 16'h0001) & ARRAY_MASK;

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			select_reg <= 3'h0;
			read_reg <= 1'b0;
			address <= 16'h0000;
			addr_valid <= 1'b0;
		end else begin
			if (start_evt) begin
				addr_valid <= 1'b0;
			end
			if (byte_done) begin
				case (state)
					SEEA_CTRL: begin
						if (ctrl_match) begin
							select_reg <= rx_select;
							read_reg <= rx_read;
							addr_valid <= rx_read;
						end
					end
					SEEA_ADDR_HI: address <= hi_loaded;
					SEEA_ADDR_LO: begin
						address <= lo_loaded;
						addr_valid <= 1'b1;
					end
					default: address <= address;
				endcase
			end else if (addr_advance_i && (state == SEEA_DATA)) begin
				address <= next_addr;
			end
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	assign sda_o = 1'b0;
	assign sda_oe_o = ack_drive;
	assign cmd_o = '{select: select_reg, read: read_reg, word_address: address};
	assign selected_o = (state == SEEA_DATA) && frame_seen;
	assign address_valid_o = addr_valid;
	assign start_pulse_o = start_evt;
	assign stop_pulse_o = stop_evt;
endmodule // seea_addressing

// ===== design/seea_event_xfer.sv
// Toggle based event crossing from the link clock into the reference clock
`timescale 1ns/100ps
module seea_event_xfer (
	input wire logic src_clk_i,
	input wire logic src_rst_n_i,
	input wire logic src_pulse_i,
	input wire logic dst_clk_i,
	input wire logic dst_rst_n_i,
	output logic dst_pulse_o
);
	logic src_toggle;
	logic dst_meta;
	logic dst_sync;
	logic dst_prev;

	always_ff @(posedge src_clk_i or negedge src_rst_n_i) begin
		if (!src_rst_n_i) begin
			src_toggle <= 1'b0;
		end else if (src_pulse_i) begin
			src_toggle <= ~src_toggle;
		end
	end

	always_ff @(posedge dst_clk_i or negedge dst_rst_n_i) begin
		if (!dst_rst_n_i) begin
			dst_meta <= 1'b0;
			dst_sync <= 1'b0;
			dst_prev <= 1'b0;
		end else begin
			dst_meta <= src_toggle;
			dst_sync <= dst_meta;
			dst_prev <= dst_sync;
		end
	end

	assign dst_pulse_o = dst_sync ^ dst_prev;
endmodule // seea_event_xfer

// ===== design/seea_sync.sv
// Two-flop synchroniser for asynchronous levels
`timescale 1ns/100ps
module seea_sync #(
	parameter int WIDTH = 2,
	parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] stage1;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stage1 <= RESET_VALUE;
			sync_o <= RESET_VALUE;
		end else begin
			stage1 <= async_i;
			sync_o <= stage1;
		end
	end
endmodule // seea_sync

// ===== testbench/seea_addressing_sva.sv
// Assertion checker for the serial EEPROM addressing front end
`timescale 1ns/100ps
module seea_addressing_sva #(
	parameter int DENSITY_KBIT = 64,
	parameter bit HAS_ADDR_PINS = 1'b1
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic [2:0] chip_address_i,
	input wire logic write_busy_i,
	input wire logic addr_advance_i,
	input wire seea_pkg::seea_cmd_t cmd_o,
	input wire logic selected_o,
	input wire logic address_valid_o,
	input wire logic start_pulse_o,
	input wire logic stop_pulse_o
);
	import seea_pkg::*;
	// ==========================================
	// Checks
	localparam logic [15:0] ADDR_MASK = 16'(DENSITY_KBIT * 128 - 1);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	a_ack_pulls_low: assert property (sda_oe_o |-> sda_o == 1'b0)
		else $error("data driven high");
	a_ack_scl_low: assert property ($rose(sda_oe_o) |-> !scl_i)
		else $error("acknowledge began with clock high");
	a_ack_holds: assert property ($rose(sda_oe_o) |-> sda_oe_o [*3])
		else $error("acknowledge too short");
	a_start_single: assert property (start_pulse_o |=> !start_pulse_o)
		else $error("start pulse too long");
	a_stop_single: assert property ($rose(stop_pulse_o) |=> $fell(stop_pulse_o))
		else $error("stop pulse too long");
	a_start_stop_excl: assert property (!(start_pulse_o && stop_pulse_o))
		else $error("start and stop together");
	a_select_match: assert property (HAS_ADDR_PINS && $rose(selected_o)
		|-> cmd_o.select == chip_address_i)
		else $error("selected with foreign chip select");
	a_data_has_addr: assert property (selected_o |-> address_valid_o)
		else $error("data phase without address");
	a_addr_masked: assert property (address_valid_o
		|-> (cmd_o.word_address & ~ADDR_MASK) == 16'h0)
		else $error("unused address bits kept");
	a_addr_wrap: assert property (addr_advance_i && selected_o
		&& cmd_o.word_address == ADDR_MASK |-> ##[1:3] cmd_o.word_address == 16'h0000)
		else $error("address left the array");
endmodule // seea_addressing_sva

bind seea_addressing seea_addressing_sva #(
	.DENSITY_KBIT(DENSITY_KBIT),
	.HAS_ADDR_PINS(HAS_ADDR_PINS)
) i_sva (
	.ref_clk_i(ref_clk_i),
	.rst_n_i(rst_n_i),
	.scl_i(scl_i),
	.sda_i(sda_i),
	.sda_o(sda_o),
	.sda_oe_o(sda_oe_o),
	.chip_address_i(chip_address_i),
	.write_busy_i(write_busy_i),
	.addr_advance_i(addr_advance_i),
	.cmd_o(cmd_o),
	.selected_o(selected_o),
	.address_valid_o(address_valid_o),
	.start_pulse_o(start_pulse_o),
	.stop_pulse_o(stop_pulse_o)
);

// ===== testbench/seea_addressing_tb.sv
// Self-checking bench for the serial EEPROM addressing front end
`timescale 1ns/100ps
module seea_addressing_tb;
	import seea_pkg::*;
	localparam logic [2:0] PINS = 3'h5;
	logic ref_clk_i, rst_n_i, scl, m_low, sda_o, sda_oe_o, write_busy_i, addr_advance_i;
	logic selected_o, address_valid_o, start_pulse_o, stop_pulse_o;
	logic [2:0] chip_address_i;
	wire logic sda_bus;
	seea_cmd_t cmd_o;
	logic scl_b, m_low_b, sda_o_b, sda_oe_b, sel_b, valid_b;
	wire logic sda_bus_b;
	seea_cmd_t cmd_b;
	int miscompares = 0;
	int samples_checked = 0;
	int starts = 0;
	int stops = 0;
	// Open-drain data line with pull-up
	assign sda_bus = ~(m_low | (sda_oe_o & ~sda_o));
	assign sda_bus_b = ~(m_low_b | (sda_oe_b & ~sda_o_b));
	initial begin
		ref_clk_i = 1'b0;
		forever #50 ref_clk_i = ~ref_clk_i;
	end
	initial begin
		rst_n_i = 1'b0;
		write_busy_i = 1'b0;
		addr_advance_i = 1'b0;
		chip_address_i = PINS;
	end
	always @(posedge ref_clk_i) begin
		starts <= starts + (start_pulse_o === 1'b1);
		stops <= stops + (stop_pulse_o === 1'b1);
	end
	seea_addressing i_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .scl_i(scl),
		.sda_i(sda_bus), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .chip_address_i(chip_address_i),
		.write_busy_i(write_busy_i), .addr_advance_i(addr_advance_i), .cmd_o(cmd_o),
		.selected_o(selected_o), .address_valid_o(address_valid_o),
		.start_pulse_o(start_pulse_o), .stop_pulse_o(stop_pulse_o));
	seea_master_model i_mst (.sda_i(sda_bus), .scl_o(scl), .sda_low_o(m_low));
	// Pinless 8 Kbit part on a bus of its own, for the block bits and the single address byte
	seea_addressing #(.DENSITY_KBIT(8), .HAS_ADDR_PINS(1'b0)) i_dut_blk (.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i), .scl_i(scl_b), .sda_i(sda_bus_b), .sda_o(sda_o_b), .sda_oe_o(sda_oe_b),
		.chip_address_i(3'h0), .write_busy_i(1'b0), .addr_advance_i(1'b0), .cmd_o(cmd_b),
		.selected_o(sel_b), .address_valid_o(valid_b), .start_pulse_o(), .stop_pulse_o());
	seea_master_model i_mst_b (.sda_i(sda_bus_b), .scl_o(scl_b), .sda_low_o(m_low_b));
	// ==========================================
	// Helpers
	task automatic check(input logic ok, input string msg);
		samples_checked++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("Error at %0t: %s", $time, msg);
		end
	endtask
	task automatic xfer(input logic [7:0] b, input logic exp);
		logic a;
		i_mst.send_byte(b, a);
		check(a === exp, "acknowledge differs");
	endtask
	task automatic test_done();
		$display("checks %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// ==========================================
	// Scenarios
	task automatic t_write_addr();
		i_mst.start();
		xfer({4'hA, PINS, 1'b0}, 1'b1);
		xfer(8'h12, 1'b1);
		xfer(8'h34, 1'b1);
		repeat (5) @(negedge ref_clk_i);
		check(cmd_o.word_address === 16'h1234, "address order");
		check(cmd_o.read === 1'b0 && address_valid_o === 1'b1, "write setup");
		i_mst.start();
		xfer({4'hA, PINS, 1'b0}, 1'b1);
		xfer(8'hFF, 1'b1);
		xfer(8'hFF, 1'b1);
		repeat (5) @(negedge ref_clk_i);
		check(cmd_o.word_address === 16'h1FFF, "unused upper bits not ignored");
		@(posedge ref_clk_i) addr_advance_i <= 1'b1;
		@(posedge ref_clk_i) addr_advance_i <= 1'b0;
		repeat (4) @(negedge ref_clk_i);
		check(cmd_o.word_address === 16'h0000, "no wrap in array");
		i_mst.stop();
		$display("test write_addr done");
	endtask
	task automatic t_read();
		i_mst.start();
		xfer({4'hA, PINS, 1'b1}, 1'b1);
		repeat (5) @(negedge ref_clk_i);
		check(cmd_o.read === 1'b1 && address_valid_o === 1'b1, "read select");
		check(selected_o === 1'b1 && cmd_o.select === PINS, "chip not selected");
		i_mst.stop();
		$display("test read done");
	endtask
	task automatic t_codes();
		for (int c = 0; c < 16; c++) begin
			if (c != 10) begin
				i_mst.start();
				xfer({4'(c), PINS, 1'b0}, 1'b0);
				xfer({4'hA, PINS, 1'b0}, 1'b0);
				i_mst.stop();
			end
		end
		$display("test codes done");
	endtask
	task automatic t_selects();
		for (int s = 0; s < 8; s++) begin
			i_mst.start();
			xfer({4'hA, 3'(s), 1'b0}, 3'(s) == PINS);
			i_mst.stop();
		end
		$display("test selects done");
	endtask
	task automatic t_busy();
		@(posedge ref_clk_i) write_busy_i <= 1'b1;
		i_mst.start();
		xfer({4'hA, PINS, 1'b0}, 1'b0);
		i_mst.stop();
		@(posedge ref_clk_i) write_busy_i <= 1'b0;
		i_mst.start();
		xfer({4'hA, PINS, 1'b1}, 1'b1);
		i_mst.stop();
		repeat (5) @(negedge ref_clk_i);
		check(starts == 28 && stops == 27, "start or stop count");
		$display("test busy done");
	endtask
	task automatic t_small_pkg();
		@(posedge ref_clk_i) chip_address_i <= 3'h4;
		repeat (4) @(posedge ref_clk_i);
		i_mst.start();
		xfer({4'hA, 3'h0, 1'b1}, 1'b0);
		i_mst.start();
		xfer({4'hA, 3'h4, 1'b1}, 1'b1);
		repeat (5) @(negedge ref_clk_i);
		check(cmd_o.select === 3'h4 && selected_o === 1'b1, "small package select");
		i_mst.stop();
		@(posedge ref_clk_i) chip_address_i <= PINS;
		$display("test small_pkg done");
	endtask
	task automatic t_blocks();
		logic a;
		i_mst_b.start();
		i_mst_b.send_byte({4'hA, 3'h7, 1'b0}, a);
		check(a === 1'b1, "block write not acknowledged");
		i_mst_b.send_byte(8'h30, a);
		check(a === 1'b1, "single address byte not acknowledged");
		repeat (5) @(negedge ref_clk_i);
		check(cmd_b.word_address === 16'h0130 && valid_b === 1'b1, "block address");
		check(sel_b === 1'b1 && cmd_b.select === 3'h7, "block select kept");
		i_mst_b.stop();
		$display("test blocks done");
	endtask
	// ==========================================
	// Sequence and watchdog
	initial begin
		repeat (4) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		t_write_addr();
		t_read();
		t_codes();
		t_selects();
		t_busy();
		t_small_pkg();
		t_blocks();
		test_done();
	end
	initial begin
		#3000000;
		miscompares++;
		test_done();
	end
endmodule // seea_addressing_tb

// ===== testbench/seea_master_model.sv
// Behavioural two-wire bus master that drives the serial clock
`timescale 1ns/100ps
module seea_master_model #(
	parameter int HALF_NS = 1008
) (
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_low_o
);
	// Clock stands high between frames; data is open drain, released means pulled up
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	task automatic start();
		sda_low_o = 1'b0;
		#HALF_NS scl_o = 1'b1;
		#HALF_NS sda_low_o = 1'b1;
		#HALF_NS scl_o = 1'b0;
	endtask
	task automatic stop();
		#(HALF_NS / 2) sda_low_o = 1'b1;
		#(HALF_NS / 2) scl_o = 1'b1;
		#HALF_NS sda_low_o = 1'b0;
		#HALF_NS;
	endtask
	task automatic send_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			#(HALF_NS / 2) sda_low_o = ~b[i];
			#(HALF_NS / 2) scl_o = 1'b1;
			#HALF_NS scl_o = 1'b0;
		end
		#(HALF_NS / 2) sda_low_o = 1'b0;
		#(HALF_NS / 2) scl_o = 1'b1;
		#(HALF_NS / 2) ack = (sda_i === 1'b0);
		#(HALF_NS / 2) scl_o = 1'b0;
	endtask
endmodule // seea_master_model
